// ===== hw/spfp_pkg.sv
package spfp_pkg;

	// ----------------------------------------
	// programming source decode
	// ----------------------------------------
	typedef enum logic [1:0] {
		SPFP_SRC_DIGITAL,
		SPFP_SRC_VOLTAGE,
		SPFP_SRC_RESIST,
		SPFP_SRC_ILLEGAL
	} spfp_src_e;

	// switch set positions within a parameter triple {resistive, aux, digital}
	localparam int SPFP_SW_RES_BIT = 2;
	localparam int SPFP_SW_AUX_BIT = 1;
	localparam int SPFP_SW_DIG_BIT = 0;
	localparam logic [2:0] SPFP_SW_DIGITAL = 3'h1;
	localparam logic [2:0] SPFP_SW_VOLTAGE = 3'h0;
	localparam logic [2:0] SPFP_SW_RESIST  = 3'h4;

	// ----------------------------------------
	// widths and reset values
	// ----------------------------------------
	localparam int         SPFP_SET_W        = 12;
	localparam logic [11:0] SPFP_SET_RESET   = 12'h000;
	localparam logic        SPFP_KNOB_RESET  = 1'b1;

	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int SPFP_CLK_MHZ        = 100;
	localparam int SPFP_ERR_HOLD_MS    = 1000;
	localparam int SPFP_ERR_HOLD_CYC   = SPFP_ERR_HOLD_MS * 1000 * SPFP_CLK_MHZ;
	localparam int SPFP_DEB_US         = 10;
	localparam int SPFP_DEB_CYC        = SPFP_DEB_US * SPFP_CLK_MHZ;

	// ----------------------------------------
	// carriers
	// ----------------------------------------
	typedef struct packed {
		logic remote_disable;
		logic overvoltage_trip;
		logic heat_trip;
		logic mains_bad;
		logic external_shutoff_input;
	} spfp_trip_s;

	typedef struct packed {
		logic voltage_regulation_mode;
		logic current_regulation_mode;
		logic power_limit;
	} spfp_mode_s;

	typedef struct packed {
		logic disabled;
		logic high_voltage_lamp;
		logic heat_lamp;
		logic guard_trip_lamp;
		logic guard_enabled_lamp;
		logic error_lamp;
		logic voltage_knob_lamp;
		logic current_knob_lamp;
		logic power_limit_lamp;
		logic volt_reg_lamp;
		logic curr_reg_lamp;
	} spfp_lamp_s;

endpackage

// ===== hw/spfp_button.sv
`timescale 1ns/1ps
// debounce one synchronised button and pulse once per press
module spfp_button #(
	parameter int DEB_CYC = 1000
) (
	input  wire logic mclk,
	input  wire logic rst_n,
	input  wire logic level_in,
	output logic      press
);

	logic [$clog2(DEB_CYC+1)-1:0] cnt_reg;
	logic                         state_reg;
	logic                         press_reg;
	wire                          differs = level_in != state_reg;
	wire                          settled = cnt_reg == ($clog2(DEB_CYC+1))'(DEB_CYC - 1);

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_reg   <= '0;
			state_reg <= 1'b0;
			press_reg <= 1'b0;
		end else begin
			press_reg <= 1'b0;
			if (!differs) begin
				cnt_reg <= '0;
			end else if (settled) begin
				cnt_reg   <= '0;
				state_reg <= level_in;
				press_reg <= level_in;
			end else begin
				cnt_reg <= cnt_reg + 1'b1;
			end
		end
	end

	assign press = press_reg;

endmodule

// ===== hw/spfp_ctrl.sv
`timescale 1ns/1ps
// Behaviour
// - each parameter's three rear switches decode to digital, voltage or resistance source; any other setting decodes to illegal.
// - voltage and current sources are chosen independently, one active each.
// - factory switch setting means digital programming from bus or knob.
// - knob pulses raise or lower the setpoint the knob currently owns.
// - power limit lights limit lamp and darkens both regulation lamps.
// - any disable source zeroes output and lights disabled lamp.
// - overvoltage trip latches until power cycle or remote reset command.
// - heat trip disables output and clears itself when heat condition ends.
// - bad mains disables output only while it lasts, no latch.
// - enabled guard trips on change from protected mode to the other.
// - guard button while tripped clears trip, guard stays enabled.
// - otherwise guard button toggles guard on and off.
// - invalid command lights error and is discarded, settings kept.
// - knob limit error clears one second after last knob pulse.
// - power-up gives local control, zero setpoints, knob owns current.
// - knob-select press swaps knob owner and its lamps.
// - knob adjusts its parameter even when the other one limits.
// - holding show-limits displays setpoints instead of measured values.
// - remote control darkens parameter lamps and ignores knob pulses.
// - local guard enable outside both regulation modes lights error, refused.
module spfp_ctrl #(
	parameter int        SET_W        = spfp_pkg::SPFP_SET_W,
	parameter int        ERR_HOLD_CYC = spfp_pkg::SPFP_ERR_HOLD_CYC,
	parameter int        DEB_CYC      = spfp_pkg::SPFP_DEB_CYC,
	parameter logic [11:0] SET_MAX    = 12'hfff
) (
	input  wire logic                 mclk,
	input  wire logic                 nrst,
	input  wire logic [2:0]           volt_switches,
	input  wire logic [2:0]           curr_switches,
	input  wire logic                 knob_step,
	input  wire logic                 knob_up,
	input  wire logic                 knob_select_btn,
	input  wire logic                 guard_btn,
	input  wire logic                 show_limits_btn,
	input  wire spfp_pkg::spfp_mode_s reg_mode,
	input  wire logic                 overvolt_sense,
	input  wire logic                 heat_sense,
	input  wire logic                 mains_bad,
	input  wire logic                 external_shutoff_input,
	input  wire logic                 remote_control_flag,
	input  wire logic                 remote_disable,
	input  wire logic                 remote_overvolt_reset,
	input  wire logic                 remote_cmd_invalid,
	input  wire logic [SET_W-1:0]     meas_volt,
	input  wire logic [SET_W-1:0]     meas_curr,
	output spfp_pkg::spfp_src_e       volt_src,
	output spfp_pkg::spfp_src_e       curr_src,
	output logic [SET_W-1:0]          volt_setpoint,
	output logic [SET_W-1:0]          curr_setpoint,
	output logic [SET_W-1:0]          disp_volt,
	output logic [SET_W-1:0]          disp_curr,
	output logic                      output_enable,
	output spfp_pkg::spfp_lamp_s      lamps
);

	localparam int ECW = $clog2(ERR_HOLD_CYC + 1);

	// ----------------------------------------
	// reset release and input synchronisers
	// ----------------------------------------
	logic [1:0] rst_sync_reg;
	wire        rst_n = rst_sync_reg[1];

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			rst_sync_reg <= 2'h0;
		end else begin
			rst_sync_reg <= {rst_sync_reg[0], 1'b1};
		end
	end

	// switch, button, knob, sense and mode inputs pass two stages before logic reads them; remote and measurement inputs are used directly
	localparam int NSYNC = 18;
	logic [NSYNC-1:0] sync1_reg;
	logic [NSYNC-1:0] sync2_reg;
	wire  [NSYNC-1:0] raw_in = {volt_switches, curr_switches, knob_step, knob_up,
		knob_select_btn, guard_btn, show_limits_btn, overvolt_sense, heat_sense, mains_bad,
		external_shutoff_input, reg_mode};

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			sync1_reg <= '0;
			sync2_reg <= '0;
		end else begin
			sync1_reg <= raw_in;
			sync2_reg <= sync1_reg;
		end
	end

	wire [2:0]           s_vsw     = sync2_reg[17:15];
	wire [2:0]           s_csw     = sync2_reg[14:12];
	wire                 s_step    = sync2_reg[11];
	wire                 s_up      = sync2_reg[10];
	wire                 s_ksel    = sync2_reg[9];
	wire                 s_guard   = sync2_reg[8];
	wire                 s_show    = sync2_reg[7];
	wire                 s_overvolt = sync2_reg[6];
	wire                 s_heat    = sync2_reg[5];
	wire                 s_mains   = sync2_reg[4];
	wire                 s_ext     = sync2_reg[3];
	spfp_pkg::spfp_mode_s s_mode;
	assign s_mode = spfp_pkg::spfp_mode_s'(sync2_reg[2:0]);

	// ----------------------------------------
	// programming source decode
	// ----------------------------------------
	function automatic spfp_pkg::spfp_src_e spfp_decode(input logic [2:0] sw);
		spfp_pkg::spfp_src_e src;
		src = spfp_pkg::SPFP_SRC_ILLEGAL;
		if (sw == spfp_pkg::SPFP_SW_DIGITAL) src = spfp_pkg::SPFP_SRC_DIGITAL;
		if (sw == spfp_pkg::SPFP_SW_VOLTAGE) src = spfp_pkg::SPFP_SRC_VOLTAGE;
		if (sw == spfp_pkg::SPFP_SW_RESIST)  src = spfp_pkg::SPFP_SRC_RESIST;
		return src;
	endfunction

	spfp_pkg::spfp_src_e volt_src_next;
	spfp_pkg::spfp_src_e curr_src_next;
	assign volt_src_next = spfp_decode(s_vsw);
	assign curr_src_next = spfp_decode(s_csw);

	// ----------------------------------------
	// buttons and knob edge
	// ----------------------------------------
	logic ksel_press;
	logic guard_press;
	logic step_reg;

	spfp_button #(.DEB_CYC(DEB_CYC)) u_ksel (
		.mclk     (mclk),
		.rst_n    (rst_n),
		.level_in (s_ksel),
		.press    (ksel_press)
	);

	spfp_button #(.DEB_CYC(DEB_CYC)) u_guard (
		.mclk     (mclk),
		.rst_n    (rst_n),
		.level_in (s_guard),
		.press    (guard_press)
	);

	// knob_up shares the synchroniser with knob_step, so direction is settled at the edge
	wire knob_pulse = s_step && !step_reg && !remote_control_flag;

	// ----------------------------------------
	// knob ownership and setpoints
	// ----------------------------------------
	logic             knob_cur_reg;
	logic [SET_W-1:0] vset_reg;
	logic [SET_W-1:0] cset_reg;

	wire              knob_next = ksel_press ? !knob_cur_reg : knob_cur_reg;
	wire [SET_W-1:0]  own_set   = knob_cur_reg ? cset_reg : vset_reg;
	wire              at_top    = own_set == SET_MAX[SET_W-1:0];
	wire              at_bottom = own_set == '0;
	wire              knob_over = knob_pulse && (s_up ? at_top : at_bottom);
	wire              knob_ok   = knob_pulse && !knob_over;
	wire [SET_W-1:0]  stepped   = s_up ? own_set + 1'b1 : own_set - 1'b1;
	wire              own_dig   = knob_cur_reg ? (curr_src_next == spfp_pkg::SPFP_SRC_DIGITAL)
		: (volt_src_next == spfp_pkg::SPFP_SRC_DIGITAL);
	// the other parameter limiting does not matter here
	wire              do_step   = knob_ok && own_dig;
	wire [SET_W-1:0]  vset_next = (do_step && !knob_cur_reg) ? stepped : vset_reg;
	wire [SET_W-1:0]  cset_next = (do_step && knob_cur_reg) ? stepped : cset_reg;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			step_reg     <= 1'b0;
			knob_cur_reg <= spfp_pkg::SPFP_KNOB_RESET;
			vset_reg     <= spfp_pkg::SPFP_SET_RESET;
			cset_reg     <= spfp_pkg::SPFP_SET_RESET;
		end else begin
			step_reg     <= s_step;
			knob_cur_reg <= knob_next;
			vset_reg     <= vset_next;
			cset_reg     <= cset_next;
		end
	end

	// ----------------------------------------
	// protection trips
	// ----------------------------------------
	logic overvolt_latch_reg;

	// the sense line wins over a remote clear, so an uncured fault stays latched
	wire overvolt_latch_next = s_overvolt
		|| (overvolt_latch_reg && !remote_overvolt_reset);

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			overvolt_latch_reg <= 1'b0;
		end else begin
			overvolt_latch_reg <= overvolt_latch_next;
		end
	end

	// ----------------------------------------
	// crossover guard
	// ----------------------------------------
	logic guard_en_reg;
	logic guard_trip_reg;
	logic guard_volt_reg;

	wire in_reg_mode   = s_mode.voltage_regulation_mode || s_mode.current_regulation_mode;
	wire guard_refuse  = guard_press && !guard_en_reg && !in_reg_mode;
	// the guard keeps the mode that was live when it was armed
	wire protected_lost = guard_volt_reg ? s_mode.current_regulation_mode
		: s_mode.voltage_regulation_mode;
	// a cleared trip fires again at once while the other mode persists
	wire guard_fire    = guard_en_reg && !guard_trip_reg && protected_lost;
	wire guard_clear   = guard_press && guard_trip_reg;
	wire guard_toggle  = guard_press && !guard_trip_reg && !guard_refuse;
	wire guard_en_next = guard_toggle ? !guard_en_reg : guard_en_reg;
	wire guard_trip_next = guard_fire || (guard_trip_reg && !guard_clear);
	wire guard_volt_next = (guard_toggle && !guard_en_reg) ? s_mode.voltage_regulation_mode
		: guard_volt_reg;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			guard_en_reg   <= 1'b0;
			guard_trip_reg <= 1'b0;
			guard_volt_reg <= 1'b0;
		end else begin
			guard_en_reg   <= guard_en_next;
			guard_trip_reg <= guard_trip_next;
			guard_volt_reg <= guard_volt_next;
		end
	end

	// heat and mains follow their pins, so they clear without a latch
	spfp_pkg::spfp_trip_s trips;
	assign trips.remote_disable         = remote_disable;
	assign trips.overvoltage_trip       = overvolt_latch_reg;
	assign trips.heat_trip              = s_heat;
	assign trips.mains_bad              = s_mains;
	assign trips.external_shutoff_input = s_ext;
	wire any_disable = (|trips) || guard_trip_reg;

	// ----------------------------------------
	// error indicator
	// ----------------------------------------
	logic           err_reg;
	logic           err_knob_reg;
	logic [ECW-1:0] err_cnt_reg;

	// only a knob limit error times out; any other error holds until reset or until a later knob limit error times out
	wire err_set      = remote_cmd_invalid || guard_refuse;
	wire err_cnt_done = err_cnt_reg == ECW'(ERR_HOLD_CYC - 1);
	wire err_time_out = err_knob_reg && err_cnt_done && !knob_pulse;
	wire err_next     = err_set || knob_over || (err_reg && !err_time_out);
	wire err_knob_next = err_set ? 1'b0 : (knob_over ? 1'b1 : (err_time_out ? 1'b0
		: err_knob_reg));
	wire [ECW-1:0] err_cnt_next = (knob_pulse || !err_knob_reg) ? '0
		: err_cnt_reg + 1'b1;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			err_reg      <= 1'b0;
			err_knob_reg <= 1'b0;
			err_cnt_reg  <= '0;
		end else begin
			err_reg      <= err_next;
			err_knob_reg <= err_knob_next;
			err_cnt_reg  <= err_cnt_next;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	spfp_pkg::spfp_lamp_s lamps_next;
	assign lamps_next.disabled           = any_disable;
	assign lamps_next.high_voltage_lamp  = overvolt_latch_reg;
	assign lamps_next.heat_lamp          = s_heat;
	assign lamps_next.guard_trip_lamp    = guard_trip_reg;
	assign lamps_next.guard_enabled_lamp = guard_en_reg;
	assign lamps_next.error_lamp         = err_reg;
	assign lamps_next.voltage_knob_lamp  = !knob_cur_reg && !remote_control_flag;
	assign lamps_next.current_knob_lamp  = knob_cur_reg && !remote_control_flag;
	assign lamps_next.power_limit_lamp   = s_mode.power_limit;
	assign lamps_next.volt_reg_lamp      = s_mode.voltage_regulation_mode && !s_mode.power_limit;
	assign lamps_next.curr_reg_lamp      = s_mode.current_regulation_mode && !s_mode.power_limit;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			volt_src      <= spfp_pkg::SPFP_SRC_DIGITAL;
			curr_src      <= spfp_pkg::SPFP_SRC_DIGITAL;
			volt_setpoint <= spfp_pkg::SPFP_SET_RESET;
			curr_setpoint <= spfp_pkg::SPFP_SET_RESET;
			disp_volt     <= '0;
			disp_curr     <= '0;
			output_enable <= 1'b0;
			lamps         <= '0;
		end else begin
			volt_src      <= volt_src_next;
			curr_src      <= curr_src_next;
			// setpoints drop to zero, not only the enable
			volt_setpoint <= any_disable ? '0 : vset_reg;
			curr_setpoint <= any_disable ? '0 : cset_reg;
			disp_volt     <= s_show ? vset_reg : meas_volt;
			disp_curr     <= s_show ? cset_reg : meas_curr;
			output_enable <= !any_disable;
			lamps         <= lamps_next;
		end
	end

endmodule

// ===== testbench/spfp_ctrl_asserts.sv
`timescale 1ns/1ps
module spfp_ctrl_asserts #(
	parameter int SET_W = 12
) (
	input wire logic                 mclk,
	input wire logic                 nrst,
	input wire logic                 show_limits_btn,
	input wire spfp_pkg::spfp_mode_s reg_mode,
	input wire logic                 heat_sense,
	input wire logic                 external_shutoff_input,
	input wire logic                 remote_control_flag,
	input wire logic                 remote_overvolt_reset,
	input wire logic [SET_W-1:0]     volt_setpoint,
	input wire logic [SET_W-1:0]     curr_setpoint,
	input wire logic [SET_W-1:0]     disp_volt,
	input wire logic [SET_W-1:0]     disp_curr,
	input wire logic                 output_enable,
	input wire spfp_pkg::spfp_lamp_s lamps
);
	// ----------------------------------------
	// cycles since reset release, saturating
	// ----------------------------------------
	logic [3:0] rel_reg;
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst)
			rel_reg <= 4'h0;
		else if (rel_reg != 4'h8)
			rel_reg <= rel_reg + 4'h1;
	end

	default clocking @(posedge mclk); endclocking
	default disable iff (!nrst);

	// ----------------------------------------
	// properties
	// ----------------------------------------
	a_disabled_zero_out: assert property (lamps.disabled && $past(lamps.disabled) |->
		volt_setpoint == '0 && curr_setpoint == '0) else $error("setpoint live while disabled");
	a_shutoff_kills_out: assert property (external_shutoff_input[*4] |=>
		!output_enable && lamps.disabled) else $error("shutoff ignored");
	a_heat_trip_lamp: assert property (heat_sense[*4] |=>
		lamps.heat_lamp && !output_enable) else $error("heat trip ignored");
	a_overvolt_latch_held: assert property (lamps.high_voltage_lamp &&
		!remote_overvolt_reset && !$past(remote_overvolt_reset)
		&& !$past(remote_overvolt_reset, 2) |=> lamps.high_voltage_lamp)
		else $error("overvoltage latch lost");
	a_limit_lamps_set: assert property (reg_mode.power_limit[*4] |=> lamps.power_limit_lamp &&
		!lamps.volt_reg_lamp && !lamps.curr_reg_lamp) else $error("power limit lamps wrong");
	a_remote_lamps_dark: assert property (remote_control_flag[*2] |=>
		!lamps.voltage_knob_lamp && !lamps.current_knob_lamp) else $error("remote lamps lit");
	a_remote_knob_frozen: assert property (remote_control_flag[*6] ##1
		(remote_control_flag && output_enable)[*2] |->
		$stable(volt_setpoint) && $stable(curr_setpoint)) else $error("setpoint moved in remote");
	a_show_setpoint_view: assert property (show_limits_btn[*8] ##1 show_limits_btn[*4] ##0
		(output_enable && $stable(volt_setpoint) && $stable(curr_setpoint)) |->
		disp_volt == volt_setpoint && disp_curr == curr_setpoint) else $error("display wrong");
	a_knob_owner_one: assert property (rel_reg == 4'h8 && !remote_control_flag &&
		!$past(remote_control_flag) |-> lamps.voltage_knob_lamp != lamps.current_knob_lamp)
		else $error("knob owner lamps wrong");
endmodule

bind spfp_ctrl spfp_ctrl_asserts #(.SET_W(SET_W)) chk_u (
	.mclk(mclk), .nrst(nrst), .show_limits_btn(show_limits_btn), .reg_mode(reg_mode),
	.heat_sense(heat_sense), .external_shutoff_input(external_shutoff_input),
	.remote_control_flag(remote_control_flag),
	.remote_overvolt_reset(remote_overvolt_reset),
	.volt_setpoint(volt_setpoint), .curr_setpoint(curr_setpoint), .disp_volt(disp_volt),
	.disp_curr(disp_curr), .output_enable(output_enable), .lamps(lamps));

// ===== testbench/spfp_operator.sv
`timescale 1ns/1ps
// operator turning the knob: one detent is a full high and low pulse
module spfp_operator (
	input  wire logic       mclk,
	input  wire logic       go,
	input  wire logic [3:0] steps,
	input  wire logic       dir_up,
	input  wire logic       slow,
	output logic            knob_step,
	output logic            knob_up,
	output logic            busy
);
	initial begin
		int w;
		knob_step = 1'h0;
		knob_up = 1'h0;
		busy = 1'h0;
		forever begin
			@(posedge mclk);
			if (go) begin
				w = slow ? 20 : 6;
				busy <= 1'h1;
				knob_up <= dir_up;
				repeat (6) @(posedge mclk);
				for (int i = 0; i < steps; i++) begin
					knob_step <= 1'h1;
					repeat (w) @(posedge mclk);
					knob_step <= 1'h0;
					repeat (w) @(posedge mclk);
				end
				busy <= 1'h0;
			end else if (!busy)
				knob_up <= ~knob_up; // direction line wanders between turns
		end
	end
endmodule

// ===== testbench/testbench.sv
`timescale 1ns/1ps
module testbench;
	localparam int EH = 50;
	localparam logic [2:0] SW [4] = '{spfp_pkg::SPFP_SW_DIGITAL, spfp_pkg::SPFP_SW_VOLTAGE,
		spfp_pkg::SPFP_SW_RESIST, 3'h7};
	localparam spfp_pkg::spfp_src_e SRC [4] = '{spfp_pkg::SPFP_SRC_DIGITAL,
		spfp_pkg::SPFP_SRC_VOLTAGE, spfp_pkg::SPFP_SRC_RESIST, spfp_pkg::SPFP_SRC_ILLEGAL};
	logic                 mclk = 1'h0;
	logic                 nrst = 1'h0;
	logic [2:0]           vsw = 3'h1;
	logic [2:0]           csw = 3'h1;
	logic [2:0]           btn = 3'h0;
	logic [3:0]           trips = 4'h0;
	spfp_pkg::spfp_mode_s mode = 3'h4;
	logic                 ovs = 1'h0;
	logic                 remote = 1'h0;
	logic                 ovr = 1'h0;
	logic                 inv = 1'h0;
	logic [11:0]          mv = 12'h123;
	logic [11:0]          mc = 12'h456;
	logic                 go = 1'h0;
	logic [3:0]           steps = 4'h0;
	logic                 up = 1'h0;
	logic                 slow = 1'h0;
	logic                 kstep;
	logic                 kup;
	logic                 busy;
	spfp_pkg::spfp_src_e  vsrc;
	spfp_pkg::spfp_src_e  csrc;
	logic [11:0]          vset;
	logic [11:0]          cset;
	logic [11:0]          dv;
	logic [11:0]          dc;
	logic                 oe;
	spfp_pkg::spfp_lamp_s lamps;
	int                   miscompares = 0;
	int                   cmp_count = 0;

	always #5 mclk = ~mclk;

	spfp_operator op_u (.mclk(mclk), .go(go), .steps(steps), .dir_up(up), .slow(slow),
		.knob_step(kstep), .knob_up(kup), .busy(busy));

	spfp_ctrl #(.ERR_HOLD_CYC(EH), .DEB_CYC(4)) dut_u (.mclk(mclk), .nrst(nrst),
		.volt_switches(vsw), .curr_switches(csw), .knob_step(kstep), .knob_up(kup),
		.knob_select_btn(btn[0]), .guard_btn(btn[1]), .show_limits_btn(btn[2]),
		.reg_mode(mode), .overvolt_sense(ovs), .heat_sense(trips[2]), .mains_bad(trips[1]),
		.external_shutoff_input(trips[0]), .remote_control_flag(remote),
		.remote_disable(trips[3]), .remote_overvolt_reset(ovr), .remote_cmd_invalid(inv),
		.meas_volt(mv), .meas_curr(mc), .volt_src(vsrc), .curr_src(csrc),
		.volt_setpoint(vset), .curr_setpoint(cset), .disp_volt(dv), .disp_curr(dc),
		.output_enable(oe), .lamps(lamps));

	task automatic complete_run;
		if (miscompares == 0 && cmp_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("Error %0t: got %h want %h", $time, seen, exp);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
	endtask

	task automatic press(input int b);
		btn[b] <= 1'h1;
		tick(12);
		btn[b] <= 1'h0;
		tick(12);
	endtask

	task automatic turn(input logic u, input logic [3:0] n);
		up <= u;
		steps <= n;
		go <= 1'h1;
		tick(1);
		go <= 1'h0;
		for (int i = 0; i < 400; i++) begin
			tick(1);
			if (!busy)
				return;
		end
		miscompares++;
		$display("Error %0t: knob turn hung", $time);
		complete_run();
	endtask

	initial begin
		tick(12);
		nrst <= 1'h1;
		tick(10);
		chk({vset, cset, lamps.current_knob_lamp, lamps.voltage_knob_lamp, oe}, 27'h5);
		for (int i = 0; i < 4; i++) begin
			vsw <= SW[i];
			csw <= SW[3-i];
			tick(6);
			chk({vsrc, csrc}, {SRC[i], SRC[3-i]});
		end
		vsw <= 3'h1;
		csw <= 3'h1;
		tick(6);
		turn(1'h1, 4'h3);
		chk(cset, 12'h003);
		turn(1'h0, 4'h4);
		chk({cset, lamps.error_lamp}, {12'h000, 1'h1});
		tick(EH - 20);
		chk(lamps.error_lamp, 1'h1);
		tick(30);
		chk(lamps.error_lamp, 1'h0);
		press(0);
		chk({lamps.voltage_knob_lamp, lamps.current_knob_lamp}, 2'h2);
		slow <= 1'h1;
		turn(1'h1, 4'h2);
		slow <= 1'h0;
		chk({vset, cset}, {12'h002, 12'h000});
		btn[2] <= 1'h1;
		tick(14);
		chk({dv, dc}, {12'h002, 12'h000});
		btn[2] <= 1'h0;
		tick(14);
		chk({dv, dc}, {mv, mc});
		for (int i = 0; i < 4; i++) begin
			trips <= 4'h1 << i;
			tick(6);
			chk({oe, lamps.disabled, vset, lamps.heat_lamp}, {2'h1, 12'h0, i == 2});
			trips <= 4'h0;
			tick(6);
			chk({oe, lamps.disabled, vset}, {2'h2, 12'h002});
		end
		remote <= 1'h1;
		tick(3);
		chk({lamps.voltage_knob_lamp, lamps.current_knob_lamp}, 2'h0);
		turn(1'h1, 4'h2);
		chk(vset, 12'h002);
		remote <= 1'h0;
		tick(3);
		ovs <= 1'h1;
		tick(6);
		ovs <= 1'h0;
		tick(12);
		chk({oe, lamps.high_voltage_lamp, lamps.disabled}, 3'h3);
		ovr <= 1'h1;
		tick(1);
		ovr <= 1'h0;
		tick(6);
		chk({oe, lamps.high_voltage_lamp}, 2'h2);
		inv <= 1'h1;
		tick(1);
		inv <= 1'h0;
		tick(4);
		chk({lamps.error_lamp, vset, cset}, {1'h1, 12'h002, 12'h000});
		mode <= 3'h5;
		tick(6);
		chk({lamps.power_limit_lamp, lamps.volt_reg_lamp, lamps.curr_reg_lamp}, 3'h4);
		mode <= 3'h4;
		tick(6);
		press(1);
		chk({lamps.guard_enabled_lamp, lamps.volt_reg_lamp, lamps.curr_reg_lamp}, 3'h6);
		mode <= 3'h2;
		tick(8);
		chk({oe, lamps.guard_trip_lamp, lamps.disabled}, 3'h3);
		chk(lamps.curr_reg_lamp, 1'h1);
		mode <= 3'h4;
		press(1);
		chk({oe, lamps.guard_trip_lamp, lamps.guard_enabled_lamp}, 3'h5);
		chk(lamps.error_lamp, 1'h1);
		press(1);
		chk(lamps.guard_enabled_lamp, 1'h0);
		mode <= 3'h0;
		nrst <= 1'h0;
		tick(3);
		nrst <= 1'h1;
		tick(10);
		chk({vset, lamps.error_lamp, lamps.current_knob_lamp}, {12'h000, 2'h1});
		press(1);
		chk({lamps.guard_enabled_lamp, lamps.error_lamp}, 2'h1);
		complete_run();
	end
endmodule
